//--- fsc_cmd.v
// Serial flash decoder: sector lock, bank register, wide address, dynamic protection
`include "fsc_defs.vh"
`default_nettype none
// How it works
// - 26h address width follows extend bit; 25h wide
// - Only one sector unlocked at a time
// - Unlock ignores low twelve address bits
// - Unlock effective only in protected blocks
// - 24h relocks the unlocked sector, no address
// - Bank read repeats volatile bank byte
// - Bit 7 extends; low bits top address
// - 18h and C5h need latch; 17h not
// - One data byte; busy during write
// - Persistent bank write also loads volatile
// - B7h sets extend bit, no latch needed
// - 29h clears extend bit, no latch needed
// - Protect read shifts sector byte on falling edge
// - Protect read repeats byte, address fixed
// - 00h protected, FFh unprotected only
// - FBh, E1h need latch; address width rule
// - Protect write starts on chip-select rise
// - Bank transfers single line or quad
module fsc_cmd #(
   parameter SECTOR_BITS = 14,
   parameter WRITE_CYCLES = `FSC_WRITE_CYCLES
) (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Serial link pins
   input wire cs_n,
   input wire sck,
   input wire [3:0] io_in,
   output reg [3:0] io_out,
   output reg [3:0] io_oe_n,
   // Mode and status-register context
   input wire quad_command_mode,
   input wire write_enable_latch,
   input wire block_protected,
   output reg write_in_progress,
   output reg write_enable_clear,
   // Protection outputs to the array logic
   output reg unlock_valid,
   output reg [SECTOR_BITS-1:0] unlocked_sector,
   output reg [7:0] bank_address,
   output reg [7:0] bank_address_persistent,
   output wire extended_addr_enable
);
   localparam ST_OP = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_DATA = 3'h2;
   localparam ST_OUT = 3'h3;
   localparam ST_DONE = 3'h4;
   localparam K_NONE = 3'h0;
   localparam K_UNLOCK = 3'h1;
   localparam K_BANK_RD = 3'h2;
   localparam K_BANK_WR = 3'h3;
   localparam K_PROT_RD = 3'h4;
   localparam K_PROT_WR = 3'h5;

   wire cs_n_s;
   wire sck_s;
   wire [3:0] io_s;
   // Idle reset value keeps a false chip-select edge out of the first cycles
   fsc_sync #(.W(6), .RST_VAL(`FSC_PIN_IDLE)) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d({cs_n, sck, io_in}),
      .q({cs_n_s, sck_s, io_s})
   );

   reg sck_d;
   reg cs_d;
   wire rise = sck_s & ~sck_d & ~cs_n_s;
   wire fall = ~sck_s & sck_d & ~cs_n_s;
   wire cs_rise = cs_n_s & ~cs_d;

   reg [2:0] state;
   reg [2:0] kind;
   reg [7:0] sh;
   reg [3:0] bitcnt;
   reg [2:0] addr_left;
   reg [31:0] addr;
   reg nv_write;
   reg [7:0] wr_data;
   reg [7:0] out_byte;
   reg [3:0] out_cnt;
   reg pend_bank;
   reg pend_prot;
   reg pend_unlock;
   reg pend_wide;
   reg wide_val;
   reg [15:0] busy_cnt;
   reg [7:0] prot_mem [0:(1<<SECTOR_BITS)-1];
   integer i;

   assign extended_addr_enable = bank_address[`FSC_EXT_BIT];

   // Bits per clock and shift of the next byte
   wire [3:0] step = quad_command_mode ? 4'h4 : 4'h1;
   wire [7:0] sh_next = quad_command_mode ? {sh[3:0], io_s} : {sh[6:0], io_s[0]};
   wire byte_done = (bitcnt + step) == 4'h8;
   wire [2:0] addr_len = extended_addr_enable ? `FSC_ADDR_BYTES_WIDE
                                               : `FSC_ADDR_BYTES_NARROW;
   // Three-byte addresses take the bank register for the top byte
   wire [31:0] full_addr = (addr_left == 3'h0) ? addr : addr;
   wire [SECTOR_BITS-1:0] sector_of =
      full_addr[`FSC_SECTOR_LSB +: SECTOR_BITS];

   always @(posedge ref_clk) begin
      if (rst) begin
         sck_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         sck_d <= sck_s;
         cs_d <= cs_n_s;
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         state <= ST_OP;
         kind <= K_NONE;
         sh <= 8'h00;
         bitcnt <= 4'h0;
         addr_left <= 3'h0;
         addr <= 32'h0000_0000;
         nv_write <= 1'b0;
         wr_data <= 8'h00;
         out_byte <= 8'h00;
         out_cnt <= 4'h0;
         pend_bank <= 1'b0;
         pend_prot <= 1'b0;
         pend_unlock <= 1'b0;
         pend_wide <= 1'b0;
         wide_val <= 1'b0;
         busy_cnt <= 16'h0000;
         write_in_progress <= 1'b0;
         write_enable_clear <= 1'b0;
         unlock_valid <= 1'b0;
         unlocked_sector <= {SECTOR_BITS{1'b0}};
         bank_address <= `FSC_BANK_RESET;
         bank_address_persistent <= `FSC_BANK_RESET;
         io_out <= 4'h0;
         io_oe_n <= 4'hF;
      end else begin
         write_enable_clear <= 1'b0;
         // Internal write timer; commands are ignored while busy
         if (write_in_progress) begin
            if (busy_cnt == 16'h0000) begin
               write_in_progress <= 1'b0;
               write_enable_clear <= 1'b1;
            end else begin
               busy_cnt <= busy_cnt - 16'h0001;
            end
         end
         if (cs_n_s) begin
            state <= ST_OP;
            bitcnt <= 4'h0;
            io_oe_n <= 4'hF;
         end
         if (cs_rise) begin
            // Writes launch only on a frame ending cleanly after the data byte
            if (pend_bank) begin
               bank_address <= wr_data;
               if (nv_write) begin
                  bank_address_persistent <= wr_data;
               end
               write_in_progress <= 1'b1;
               busy_cnt <= WRITE_CYCLES[15:0];
            end
            if (pend_prot) begin
               // Values other than the two legal ones are dropped
               if (wr_data == `FSC_PROT_ON || wr_data == `FSC_PROT_OFF) begin
                  prot_mem[addr[`FSC_SECTOR_LSB +: SECTOR_BITS]] <= wr_data;
               end
               write_in_progress <= 1'b1;
               busy_cnt <= WRITE_CYCLES[15:0];
            end
            // Unlock and the B7h/29h extend commands also wait for the frame to close; 24h relocks at once
            if (pend_unlock) begin
               unlock_valid <= 1'b1;
            end
            if (pend_wide) begin
               bank_address[`FSC_EXT_BIT] <= wide_val;
            end
            pend_bank <= 1'b0;
            pend_prot <= 1'b0;
            pend_unlock <= 1'b0;
            pend_wide <= 1'b0;
         end else if (rise && state != ST_OUT) begin
            sh <= sh_next;
            bitcnt <= byte_done ? 4'h0 : bitcnt + step;
            if (byte_done && state == ST_OP) begin
               state <= ST_DONE;
               kind <= K_NONE;
               addr <= {bank_address[6:0], 25'h0000000} & 32'hFF00_0000;
               if (!write_in_progress) begin
                  case (sh_next)
                     `FSC_OP_SEC_UNLOCK: begin
                        kind <= K_UNLOCK;
                        state <= ST_ADDR;
                        addr_left <= addr_len;
                        addr <= {bank_address, 24'h000000};
                     end
                     `FSC_OP_SEC_UNLOCK_W: begin
                        kind <= K_UNLOCK;
                        state <= ST_ADDR;
                        addr_left <= `FSC_ADDR_BYTES_WIDE;
                     end
                     `FSC_OP_SEC_RELOCK: unlock_valid <= 1'b0;
                     `FSC_OP_BANK_RD_A, `FSC_OP_BANK_RD_B: begin
                        kind <= K_BANK_RD;
                        state <= ST_OUT;
                        out_byte <= bank_address;
                        out_cnt <= 4'h0;
                     end
                     `FSC_OP_BANK_WR_NV, `FSC_OP_BANK_WR_V_WEL: begin
                        if (write_enable_latch) begin
                           kind <= K_BANK_WR;
                           state <= ST_DATA;
                           nv_write <= (sh_next == `FSC_OP_BANK_WR_NV);
                        end
                     end
                     `FSC_OP_BANK_WR_V: begin
                        kind <= K_BANK_WR;
                        state <= ST_DATA;
                        nv_write <= 1'b0;
                     end
                     `FSC_OP_ENTER_WIDE: begin
                        pend_wide <= 1'b1;
                        wide_val <= 1'b1;
                     end
                     `FSC_OP_EXIT_WIDE: begin
                        pend_wide <= 1'b1;
                        wide_val <= 1'b0;
                     end
                     `FSC_OP_PROT_RD, `FSC_OP_PROT_WR: begin
                        kind <= (sh_next == `FSC_OP_PROT_RD) ? K_PROT_RD : K_PROT_WR;
                        if (sh_next == `FSC_OP_PROT_RD || write_enable_latch) begin
                           state <= ST_ADDR;
                        end
                        addr_left <= addr_len;
                        addr <= {bank_address, 24'h000000};
                     end
                     `FSC_OP_PROT_RD_W, `FSC_OP_PROT_WR_W: begin
                        kind <= (sh_next == `FSC_OP_PROT_RD_W) ? K_PROT_RD : K_PROT_WR;
                        if (sh_next == `FSC_OP_PROT_RD_W || write_enable_latch) begin
                           state <= ST_ADDR;
                        end
                        addr_left <= `FSC_ADDR_BYTES_WIDE;
                     end
                     default: state <= ST_DONE;
                  endcase
               end
            end else if (byte_done && state == ST_ADDR) begin
               if (addr_left == `FSC_ADDR_BYTES_WIDE) begin
                  addr[31:24] <= sh_next;
               end else if (addr_left == 3'h3) begin
                  addr[23:16] <= sh_next;
               end else if (addr_left == 3'h2) begin
                  addr[15:8] <= sh_next;
               end else begin
                  addr[7:0] <= sh_next;
               end
               addr_left <= addr_left - 3'h1;
               if (addr_left == 3'h1) begin
                  if (kind == K_UNLOCK) begin
                     state <= ST_DONE;
                     // A second unlock is dropped while one sector is unlocked; it is not kept for after a relock
                     if (!unlock_valid && block_protected) begin
                        pend_unlock <= 1'b1;
                        unlocked_sector <= addr[`FSC_SECTOR_LSB +: SECTOR_BITS];
                     end
                  end else if (kind == K_PROT_RD) begin
                     state <= ST_OUT;
                     out_byte <= prot_mem[addr[`FSC_SECTOR_LSB +: SECTOR_BITS]];
                     out_cnt <= 4'h0;
                  end else begin
                     state <= ST_DATA;
                  end
               end
            end else if (byte_done && state == ST_DATA) begin
               wr_data <= sh_next;
               state <= ST_DONE;
               if (kind == K_BANK_WR) begin
                  pend_bank <= 1'b1;
               end else begin
                  pend_prot <= 1'b1;
               end
            end else if (state == ST_DONE) begin
               // Clocks beyond the last byte cancel whatever waits for the frame end
               pend_bank <= 1'b0;
               pend_prot <= 1'b0;
               pend_unlock <= 1'b0;
               pend_wide <= 1'b0;
            end
         end else if (fall && state == ST_OUT) begin
            // Repeating byte: the same value each eight bits
            if (quad_command_mode) begin
               io_out <= out_cnt[2] ? out_byte[3:0] : out_byte[7:4];
               io_oe_n <= 4'h0;
            end else begin
               io_out <= {2'b00, out_byte[3'h7 - out_cnt[2:0]], 1'b0};
               io_oe_n <= 4'hD;
            end
            out_cnt <= (out_cnt + step) & 4'h7;
         end
      end
   end

   initial begin
      for (i = 0; i < (1<<SECTOR_BITS); i = i + 1) begin
         prot_mem[i] = `FSC_PROT_OFF;
      end
   end

   wire unused_ok = &{1'b0, full_addr[0], sector_of[0]};
endmodule
`default_nettype wire

//--- fsc_defs.vh
// Command codes, field positions and reset values for the flash command decoder
`ifndef FSC_DEFS_VH
`define FSC_DEFS_VH
`define FSC_OP_SEC_UNLOCK 8'h26
`define FSC_OP_SEC_UNLOCK_W 8'h25
`define FSC_OP_SEC_RELOCK 8'h24
`define FSC_OP_BANK_RD_A 8'h16
`define FSC_OP_BANK_RD_B 8'hC8
`define FSC_OP_BANK_WR_NV 8'h18
`define FSC_OP_BANK_WR_V_WEL 8'hC5
`define FSC_OP_BANK_WR_V 8'h17
`define FSC_OP_ENTER_WIDE 8'hB7
`define FSC_OP_EXIT_WIDE 8'h29
`define FSC_OP_PROT_RD 8'hFA
`define FSC_OP_PROT_RD_W 8'hE0
`define FSC_OP_PROT_WR 8'hFB
`define FSC_OP_PROT_WR_W 8'hE1
`define FSC_EXT_BIT 7
`define FSC_BANK_RESET 8'h00
`define FSC_PROT_ON 8'h00
`define FSC_PROT_OFF 8'hFF
`define FSC_SECTOR_LSB 12
`define FSC_ADDR_BYTES_NARROW 3'h3
`define FSC_ADDR_BYTES_WIDE 3'h4
`define FSC_WRITE_CYCLES 16'h0010
// Synchroniser reset equals the idle pins {cs_n, sck, io}: deselected, clock low
`define FSC_PIN_IDLE 6'h20
`endif

//--- fsc_sync.v
// Two-stage synchroniser for pin inputs
`default_nettype none
module fsc_sync #(
   parameter W = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input wire ref_clk,
   input wire rst,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta;
   always @(posedge ref_clk) begin
      if (rst) begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

//--- fsc_checker.sv
// Port-level concurrent checks for the flash command decoder
`default_nettype none
module fsc_checker #(
   parameter SECTOR_BITS = 14,
   parameter WRITE_CYCLES = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Serial pins
   input wire logic cs_n,
   input wire logic sck,
   input wire logic [3:0] io_in,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe_n,
   // Status context
   input wire logic quad_command_mode,
   input wire logic write_enable_latch,
   input wire logic block_protected,
   input wire logic write_in_progress,
   input wire logic write_enable_clear,
   // Protection state
   input wire logic unlock_valid,
   input wire logic [SECTOR_BITS-1:0] unlocked_sector,
   input wire logic [7:0] bank_address,
   input wire logic [7:0] bank_address_persistent,
   input wire logic extended_addr_enable
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_ext_bit: assert property (extended_addr_enable == bank_address[7])
      else $error("extend flag differs from bank bit 7");
   chk_idle_release: assert property (cs_n [*6] |-> io_oe_n == 4'hF)
      else $error("lines driven while deselected");
   chk_drive_lines: assert property
      (io_oe_n != 4'hF |-> io_oe_n == (quad_command_mode ? 4'h0 : 4'hD))
      else $error("wrong output lines enabled");
   chk_busy_len: assert property ($rose(write_in_progress) |-> write_in_progress [*8])
      else $error("busy flag too short");
   chk_busy_end: assert property
      ($fell(write_in_progress) |-> ##[0:1] write_enable_clear)
      else $error("no latch clear at write end");
   chk_launch_idle: assert property ($changed(bank_address) |-> cs_n)
      else $error("bank changed inside a frame");
   chk_nv_copy: assert property ($changed(bank_address_persistent) |->
      write_enable_latch ##[0:1] bank_address == bank_address_persistent)
      else $error("persistent write not copied or not enabled");
   chk_one_sector: assert property (unlock_valid && $past(unlock_valid) |->
      unlocked_sector == $past(unlocked_sector))
      else $error("sector changed while unlocked");
   chk_unlock_cause: assert property ($rose(unlock_valid) |-> block_protected && cs_n)
      else $error("unlock outside protected block");
endmodule
`default_nettype wire

//--- fsc_host.sv
// Host controller model that frames commands on the serial pins
`default_nettype none
module fsc_host (
   // Clock and mode
   input wire logic ref_clk,
   input wire logic quad_command_mode,
   // Serial pins
   input wire logic [3:0] io_out,
   output logic cs_n,
   output logic sck,
   output logic [3:0] io_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rx;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      io_in = 4'hF;
   end
   // Four ref_clk per phase keeps the link at 200 ns
   task automatic half();
      repeat (4) @(negedge ref_clk);
   endtask
   task automatic xfer(input logic [7:0] tx);
      for (int n = quad_command_mode ? 1 : 7; n >= 0; n--) begin
         io_in <= quad_command_mode ? tx[n*4 +: 4] : {3'h7, tx[n]};
         half();
         rx = quad_command_mode ? {rx[3:0], io_out} : {rx[6:0], io_out[1]};
         sck <= 1'b1;
         half();
         sck <= 1'b0;
      end
   endtask
   task automatic frame(input logic [7:0] op, input int na, input logic [31:0] a,
      input int nd, input logic [7:0] d, output logic [7:0] r0, output logic [7:0] r1);
      cs_n <= 1'b0;
      half();
      xfer(op);
      for (int i = na - 1; i >= 0; i--) xfer(a[i*8 +: 8]);
      for (int i = 0; i < nd; i++) begin
         xfer(d);
         if (i == 0) r0 = rx;
         r1 = rx;
      end
      half();
      cs_n <= 1'b1;
      half();
      // Released line shows no stale bit
      io_in <= ~io_in;
   endtask
endmodule
`default_nettype wire

//--- fsc_cmd_bench.sv
// Self-checking bench for the flash command decoder
`default_nettype none
module fsc_cmd_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SB = 14;
   logic ref_clk = 1'b0, rst = 1'b1, cs_n, sck, quad_command_mode = 1'b0;
   logic write_enable_latch = 1'b0, block_protected = 1'b1;
   logic [3:0] io_in, io_out, io_oe_n;
   logic write_in_progress, write_enable_clear, unlock_valid, extended_addr_enable;
   logic [SB-1:0] unlocked_sector;
   logic [7:0] bank_address, bank_address_persistent, r0, r1;
   int fails = 0, cmp_count = 0;
   always #12.5 ref_clk = ~ref_clk;
   fsc_cmd #(.SECTOR_BITS(SB)) dut_u (
      .ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .io_in(io_in),
      .io_out(io_out), .io_oe_n(io_oe_n), .quad_command_mode(quad_command_mode),
      .write_enable_latch(write_enable_latch), .block_protected(block_protected),
      .write_in_progress(write_in_progress), .write_enable_clear(write_enable_clear),
      .unlock_valid(unlock_valid), .unlocked_sector(unlocked_sector),
      .bank_address(bank_address), .bank_address_persistent(bank_address_persistent),
      .extended_addr_enable(extended_addr_enable)
   );
   fsc_host host_u (
      .ref_clk(ref_clk), .quad_command_mode(quad_command_mode), .io_out(io_out),
      .cs_n(cs_n), .sck(sck), .io_in(io_in)
   );
   // The host drops its latch copy when the device reports write end
   always @(negedge ref_clk) if (write_enable_clear === 1'b1) write_enable_latch <= 1'b0;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic run(input logic [7:0] op, input int na, input logic [31:0] a,
      input int nd, input logic [7:0] d);
      host_u.frame(op, na, a, nd, d, r0, r1);
      repeat (8) @(negedge ref_clk);
      for (int i = 0; i < 300 && write_in_progress !== 1'b0; i++) @(negedge ref_clk);
      chk(write_in_progress, 1'b0);
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic pread(input logic [7:0] op, input int na, input logic [31:0] a,
      input logic [15:0] exp);
      run(op, na, a, 2, 8'hA5);
      chk({r0, r1}, exp);
   endtask
   task automatic sec(input logic [15:0] exp);
      chk({unlock_valid, 1'b0, unlocked_sector}, exp);
   endtask
   initial begin
      repeat (16) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      pread(8'h16, 0, 0, 16'h0000);
      run(8'h17, 0, 0, 1, 8'h05);
      chk({bank_address_persistent, bank_address}, 16'h0005);
      pread(8'hC8, 0, 0, 16'h0505);
      run(8'hC5, 0, 0, 1, 8'h03);
      chk(bank_address, 8'h05);
      write_enable_latch = 1'b1;
      run(8'hC5, 0, 0, 1, 8'h03);
      chk(bank_address, 8'h03);
      write_enable_latch = 1'b1;
      run(8'h18, 0, 0, 1, 8'h02);
      chk({bank_address_persistent, bank_address}, 16'h0202);
      chk(write_enable_latch, 1'b0);
      run(8'hB7, 0, 0, 0, 0);
      chk({bank_address_persistent, bank_address}, 16'h0282);
      chk(extended_addr_enable, 1'b1);
      run(8'h29, 0, 0, 0, 0);
      chk({bank_address_persistent, bank_address}, 16'h0202);
      // Trailing clocks after an opcode-only or one-byte command cancel it
      run(8'hB7, 0, 0, 1, 8'h00);
      chk(extended_addr_enable, 1'b0);
      run(8'h17, 0, 0, 2, 8'h07);
      chk(bank_address, 8'h02);
      $display("bank register test done");
      // Bank 02 supplies the bits above A23: sector 2123
      run(8'h26, 3, 32'h00123FFF, 0, 0);
      sec(16'hA123);
      run(8'h25, 4, 32'h01456000, 0, 0);
      sec(16'hA123);
      run(8'h24, 0, 0, 0, 0);
      sec(16'h2123);
      block_protected = 1'b0;
      run(8'h25, 4, 32'h01456000, 0, 0);
      chk(unlock_valid, 1'b0);
      block_protected = 1'b1;
      run(8'hB7, 0, 0, 0, 0);
      run(8'h26, 4, 32'h01456ABC, 0, 0);
      sec(16'h9456);
      run(8'h24, 0, 0, 0, 0);
      chk(unlock_valid, 1'b0);
      $display("sector lock test done");
      pread(8'hFA, 4, 32'h02123000, 16'hFFFF);
      run(8'hFB, 4, 32'h02123000, 1, 8'h00);
      pread(8'hFA, 4, 32'h02123000, 16'hFFFF);
      write_enable_latch = 1'b1;
      run(8'hFB, 4, 32'h02123000, 1, 8'h5A);
      pread(8'hE0, 4, 32'h02123000, 16'hFFFF);
      write_enable_latch = 1'b1;
      run(8'hFB, 4, 32'h02123000, 1, 8'h00);
      pread(8'hE0, 4, 32'h02123000, 16'h0000);
      run(8'h29, 0, 0, 0, 0);
      write_enable_latch = 1'b1;
      run(8'hE1, 4, 32'h02456000, 1, 8'h00);
      pread(8'hFA, 3, 32'h00456000, 16'h0000);
      pread(8'hFA, 3, 32'h00123000, 16'h0000);
      quad_command_mode = 1'b1;
      pread(8'h16, 0, 0, 16'h0202);
      pread(8'hE0, 4, 32'h02789000, 16'hFFFF);
      quad_command_mode = 1'b0;
      $display("protection byte test done");
      finish_test();
   end
   initial begin
      #1ms;
      fails++;
      finish_test();
   end
endmodule
bind fsc_cmd fsc_checker #(.SECTOR_BITS(SECTOR_BITS), .WRITE_CYCLES(WRITE_CYCLES)) chk_u (
   .ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .io_in(io_in), .io_out(io_out),
   .io_oe_n(io_oe_n), .quad_command_mode(quad_command_mode),
   .write_enable_latch(write_enable_latch), .block_protected(block_protected),
   .write_in_progress(write_in_progress), .write_enable_clear(write_enable_clear),
   .unlock_valid(unlock_valid), .unlocked_sector(unlocked_sector),
   .bank_address(bank_address), .bank_address_persistent(bank_address_persistent),
   .extended_addr_enable(extended_addr_enable)
);
`default_nettype wire
